// ===== uet_pkg.sv
// Constants and types shared by the endpoint transaction handler
package uet_pkg;
   localparam logic [3:0] PID_OUT = 4'h1;
   localparam logic [3:0] PID_IN = 4'h9;
   localparam logic [3:0] PID_SOF = 4'h5;
   localparam logic [3:0] PID_SETUP = 4'hd;
   localparam logic [3:0] PID_DATA0 = 4'h3;
   localparam logic [3:0] PID_DATA1 = 4'hb;
   localparam logic [3:0] PID_ACK = 4'h2;
   localparam logic [3:0] PID_NAK = 4'ha;
   localparam logic [3:0] PID_STALL = 4'he;
   localparam logic [3:0] PID_PRE = 4'hc;
   localparam int NUM_EP = 3;
   localparam logic [3:0] EP_MAX = 4'h2;
   localparam logic [1:0] EP_CTL = 2'h0;
   localparam logic [1:0] EP_BULK_OUT = 2'h1;
   localparam logic [1:0] EP_BULK_IN = 2'h2;
   localparam logic [6:0] DEFAULT_ADDR = 7'h00;
   localparam logic [7:0] REQ_SET_ADDRESS = 8'h05;
   localparam logic [3:0] SETUP_LEN = 4'h8;
   localparam logic [3:0] SETUP_IDX_TYPE = 4'h0;
   localparam logic [3:0] SETUP_IDX_REQ = 4'h1;
   localparam logic [3:0] SETUP_IDX_VALUE = 4'h2;
   localparam logic [3:0] SETUP_IDX_LEN_LO = 4'h6;
   localparam logic [3:0] SETUP_IDX_LEN_HI = 4'h7;
   localparam int REQ_DIR_BIT = 7;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int CLK_PERIOD_NS = 20;
   localparam int HS_WAIT_NS = 1333;
   // Longest wait, so the figure rounds down
   localparam int HS_WAIT_CYCLES = HS_WAIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RX_DATA = 2'b01,
      ST_TX_WAIT = 2'b10,
      ST_HS_WAIT = 2'b11
   } uet_state_t;

   typedef enum logic [2:0] {
      CS_IDLE = 3'b000,
      CS_DATA_OUT = 3'b001,
      CS_DATA_IN = 3'b010,
      CS_STATUS_OUT = 3'b011,
      CS_STATUS_IN = 3'b100
   } uet_ctl_t;
endpackage

// ===== uet_stream_if.sv
// Valid/ready byte stream between the handler and its FIFO
`timescale 1ns/1ps
interface uet_stream_if #(parameter int WIDTH = 8);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ===== uet_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module uet_fifo #(
   parameter int WIDTH = uet_pkg::FIFO_WIDTH,
   parameter int DEPTH = uet_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_n,
   uet_stream_if.snk wr,
   uet_stream_if.src rd
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
   logic [CW-1:0] count, next_count;
   logic doWrite, doRead;

   assign wr.ready = (count != FULL_COUNT);
   assign rd.valid = (count != '0);
   assign rd.data = mem[rdPtr];
   assign doWrite = wr.valid && wr.ready;
   assign doRead = rd.valid && rd.ready;

   always_comb begin
      next_wrPtr = wrPtr;
      next_rdPtr = rdPtr;
      next_count = count;
      if (doWrite) begin
         next_wrPtr = (wrPtr == LAST_IDX) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
         next_rdPtr = (rdPtr == LAST_IDX) ? '0 : rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
         next_count = count + 1'b1;
      end else if (doRead && !doWrite) begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         wrPtr <= next_wrPtr;
         rdPtr <= next_rdPtr;
         count <= next_count;
      end
   end

   // Storage needs no reset; only the pointers and count define what is valid
   always_ff @(posedge mclk) begin
      if (doWrite) begin
         mem[wrPtr] <= wr.data;
      end
   end

   AST_FIFO_BOUND: assert property (@(posedge mclk) disable iff (!rst_n)
      (count == FULL_COUNT) && !doRead |=> (count == FULL_COUNT))
      else $error("FIFO lost or gained a word while full");
endmodule

// ===== uet_transaction_handler.sv
// Endpoint transaction handler: token decode, handshakes, data toggles, control stages
`timescale 1ns/1ps
// Summary of operation
// [R1] Only host tokens start work; device answers, one direction at a time.
// [R2] Endpoints 1 and 2 are bulk only: 1 receives, 2 sends.
// [R3] IN with data ready sends DATA0/DATA1, host then acknowledges.
// [R4] IN with nothing ready gets NAK and no data.
// [R5] Stalled endpoint answers IN and OUT data with STALL.
// [R6] Host sends no handshake after a corrupt data packet.
// [R7] Good accepted OUT data packet is acknowledged with ACK.
// [R8] OUT data that cannot be taken now is answered NAK.
// [R9] Corrupt OUT or SETUP data packet gets no handshake at all.
// [R10] Endpoint 0 is the control endpoint and takes control traffic only.
// [R11] Control transaction is SETUP, DATA0 packet, then handshake.
// [R12] SETUP data packet gets ACK, or silence on a reception error.
// [R13] Host sends exactly eight request bytes after each SETUP.
// [R14] Control data stage starts with DATA1, then alternates.
// [R15] Control write continues with OUT, control read with IN.
// [R16] Status stage always uses DATA1 and runs opposite to data.
// [R17] Zero-length DATA0 and DATA1 packets are accepted and sent.
// [R18] Interrupt transactions are handled exactly like bulk.
// [R19] Request bytes from endpoint 0 go into the FIFO for software.
// [R20] Address request sets the 7-bit device address for later traffic.
// [R21] Software drains OUT FIFO before applying a new configuration.
// [R22] DMA is reprogrammed for every packet, driven by endpoint events.
// [R23] Packets over twelve bytes should be multiples of four for DMA.
// [R24] Tokens to another address are ignored; address resets to zero.
// [R25] Only endpoint numbers 0 to 2 are valid.
// [R26] Start-of-frame and preamble traffic is silently ignored.
module uet_transaction_handler #(
   parameter int FIFO_DEPTH = uet_pkg::FIFO_DEPTH,
   parameter logic [15:0] HS_WAIT = 16'(uet_pkg::HS_WAIT_CYCLES)
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic busReset,
   input wire logic rxPktValid,
   input wire logic [3:0] rxPid,
   input wire logic rxPidOk,
   input wire logic rxCrcOk,
   input wire logic [6:0] rxAddr,
   input wire logic [3:0] rxEndp,
   input wire logic rxByteValid,
   input wire logic [7:0] rxByte,
   input wire logic txDone,
   input wire logic [2:0] inReady,
   input wire logic [2:0] epStall,
   input wire logic [2:0] outEnable,
   input wire logic ep0DataEnd,
   input wire logic fifoReady,
   output logic fifoValid,
   output logic [7:0] fifoData,
   output logic txHsValid,
   output logic [3:0] txHsPid,
   output logic txDataReq,
   output logic [3:0] txDataPid,
   output logic [1:0] txDataEp,
   output logic txZeroLen,
   output logic rxPktEvent,
   output logic [1:0] rxPktEp,
   output logic inAckEvent,
   output logic [1:0] inAckEp,
   output logic setupEvent,
   output logic [6:0] devAddr,
   output logic [2:0] ctlStage
);
   localparam int HS_BOUND = 70;

   uet_pkg::uet_state_t state, next_state;
   uet_pkg::uet_ctl_t stage, next_stage;
   logic [1:0] ep, next_ep;
   logic isSetup, next_isSetup;
   logic overrun, next_overrun;
   logic [3:0] byteCnt, next_byteCnt;
   logic reqDirIn, next_reqDirIn;
   logic reqSetAddr, next_reqSetAddr;
   logic [6:0] pendAddr, next_pendAddr;
   logic lenLoZero, next_lenLoZero;
   logic lenZero, next_lenZero;
   logic [2:0] tog, next_tog;
   logic [15:0] hsTimer, next_hsTimer;
   logic [6:0] next_devAddr;
   logic next_txHsValid, next_txDataReq, next_txZeroLen;
   logic [3:0] next_txHsPid, next_txDataPid;
   logic [1:0] next_txDataEp, next_rxPktEp, next_inAckEp;
   logic next_rxPktEvent, next_inAckEvent, next_setupEvent;
   logic tokOk, dataOk, acceptByte;
   logic [1:0] epTok;

   uet_stream_if #(.WIDTH(uet_pkg::FIFO_WIDTH)) wrIf ();
   uet_stream_if #(.WIDTH(uet_pkg::FIFO_WIDTH)) rdIf ();

   uet_fifo #(.WIDTH(uet_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rxFifo (
      .mclk(mclk),
      .rst_n(rst_n),
      .wr(wrIf.snk),
      .rd(rdIf.src)
   );

   assign fifoValid = rdIf.valid;
   assign fifoData = rdIf.data;
   assign rdIf.ready = fifoReady;
   assign ctlStage = stage;

   assign tokOk = rxPidOk && rxCrcOk && (rxAddr == devAddr) && (rxEndp <= uet_pkg::EP_MAX); // [R24] [R25]
   assign epTok = rxEndp[1:0];
   assign dataOk = rxPidOk && rxCrcOk && ((rxPid == uet_pkg::PID_DATA0) || (rxPid == uet_pkg::PID_DATA1));
   // Setup bytes always go in; bulk bytes only to an open, unstalled receive endpoint
   assign acceptByte = (state == uet_pkg::ST_RX_DATA) && (ep != uet_pkg::EP_BULK_IN)
      && (isSetup || (!epStall[ep] && outEnable[ep]));
   // Bytes are streamed before the CRC verdict; software discards a packet without an event
   assign wrIf.valid = acceptByte && rxByteValid; // [R19]
   assign wrIf.data = rxByte;

   always_comb begin
      next_state = state;
      next_stage = stage;
      next_ep = ep;
      next_isSetup = isSetup;
      next_overrun = overrun;
      next_byteCnt = byteCnt;
      next_reqDirIn = reqDirIn;
      next_reqSetAddr = reqSetAddr;
      next_pendAddr = pendAddr;
      next_lenLoZero = lenLoZero;
      next_lenZero = lenZero;
      next_tog = tog;
      next_hsTimer = hsTimer;
      next_devAddr = devAddr;
      next_txHsValid = 1'b0;
      next_txHsPid = txHsPid;
      next_txDataReq = 1'b0;
      next_txDataPid = txDataPid;
      next_txDataEp = txDataEp;
      next_txZeroLen = txZeroLen;
      next_rxPktEvent = 1'b0;
      next_rxPktEp = rxPktEp;
      next_inAckEvent = 1'b0;
      next_inAckEp = inAckEp;
      next_setupEvent = 1'b0;
      case (state)
         uet_pkg::ST_IDLE: begin
            // Nothing happens without a host token; SOF and PRE fall to default
            if (rxPktValid && tokOk) begin // [R1] [R26]
               case (rxPid)
                  uet_pkg::PID_SETUP: begin
                     if (epTok == uet_pkg::EP_CTL) begin // [R10] [R11]
                        next_state = uet_pkg::ST_RX_DATA;
                        next_isSetup = 1'b1;
                        next_ep = epTok;
                        next_overrun = 1'b0;
                        next_byteCnt = '0;
                        next_reqSetAddr = 1'b0;
                     end
                  end
                  uet_pkg::PID_OUT: begin
                     next_state = uet_pkg::ST_RX_DATA;
                     next_isSetup = 1'b0;
                     next_ep = epTok;
                     next_overrun = 1'b0;
                     if (epTok == uet_pkg::EP_CTL && stage == uet_pkg::CS_DATA_IN) begin
                        next_stage = uet_pkg::CS_STATUS_OUT; // [R16]
                        next_tog[0] = 1'b1; // [R16]
                     end
                  end
                  uet_pkg::PID_IN: begin
                     next_ep = epTok;
                     next_txDataEp = epTok;
                     if (epStall[epTok] || epTok == uet_pkg::EP_BULK_OUT) begin
                        next_txHsValid = 1'b1; // [R5] [R2]
                        next_txHsPid = uet_pkg::PID_STALL;
                     end else if (epTok == uet_pkg::EP_CTL
                        && (stage == uet_pkg::CS_DATA_OUT || stage == uet_pkg::CS_STATUS_IN)) begin
                        if (ep0DataEnd) begin
                           next_txDataReq = 1'b1; // [R15] [R16] [R17]
                           next_txDataPid = uet_pkg::PID_DATA1;
                           next_txZeroLen = 1'b1;
                           next_stage = uet_pkg::CS_STATUS_IN;
                           next_state = uet_pkg::ST_TX_WAIT;
                        end else begin
                           next_txHsValid = 1'b1;
                           next_txHsPid = uet_pkg::PID_NAK;
                        end
                     end else if (epTok == uet_pkg::EP_CTL && stage != uet_pkg::CS_DATA_IN) begin
                        next_txHsValid = 1'b1; // [R10]
                        next_txHsPid = uet_pkg::PID_STALL;
                     end else if (inReady[epTok]) begin
                        // Interrupt polls take this same path as bulk
                        next_txDataReq = 1'b1; // [R3] [R18]
                        next_txDataPid = tog[epTok] ? uet_pkg::PID_DATA1 : uet_pkg::PID_DATA0;
                        next_txZeroLen = 1'b0;
                        next_state = uet_pkg::ST_TX_WAIT;
                     end else begin
                        next_txHsValid = 1'b1; // [R4]
                        next_txHsPid = uet_pkg::PID_NAK;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         uet_pkg::ST_RX_DATA: begin
            if (wrIf.valid && !wrIf.ready) begin
               next_overrun = 1'b1; // [R8]
            end
            if (isSetup && rxByteValid && byteCnt < uet_pkg::SETUP_LEN) begin // [R13]
               next_byteCnt = byteCnt + 1'b1;
               case (byteCnt)
                  uet_pkg::SETUP_IDX_TYPE: next_reqDirIn = rxByte[uet_pkg::REQ_DIR_BIT];
                  uet_pkg::SETUP_IDX_REQ: next_reqSetAddr = (rxByte == uet_pkg::REQ_SET_ADDRESS);
                  uet_pkg::SETUP_IDX_VALUE: next_pendAddr = rxByte[6:0];
                  uet_pkg::SETUP_IDX_LEN_LO: next_lenLoZero = (rxByte == 8'h00);
                  uet_pkg::SETUP_IDX_LEN_HI: next_lenZero = lenLoZero && (rxByte == 8'h00);
                  default: begin
                  end
               endcase
            end
            if (rxPktValid) begin
               next_state = uet_pkg::ST_IDLE;
               // A damaged packet ends here with no reply at all
               if (dataOk) begin // [R9]
                  next_rxPktEp = ep;
                  if (isSetup) begin
                     next_txHsValid = 1'b1; // [R12]
                     next_txHsPid = uet_pkg::PID_ACK;
                     next_setupEvent = 1'b1;
                     next_rxPktEvent = 1'b1;
                     next_tog[0] = 1'b1; // [R14]
                     if (lenZero) begin
                        next_stage = uet_pkg::CS_STATUS_IN;
                     end else if (reqDirIn) begin
                        next_stage = uet_pkg::CS_DATA_IN; // [R15]
                     end else begin
                        next_stage = uet_pkg::CS_DATA_OUT; // [R15]
                     end
                  end else if (ep == uet_pkg::EP_BULK_IN || epStall[ep]) begin
                     next_txHsValid = 1'b1; // [R5] [R2]
                     next_txHsPid = uet_pkg::PID_STALL;
                  end else if (overrun || !outEnable[ep]) begin
                     next_txHsValid = 1'b1; // [R8]
                     next_txHsPid = uet_pkg::PID_NAK;
                  end else begin
                     next_txHsValid = 1'b1; // [R7] [R17]
                     next_txHsPid = uet_pkg::PID_ACK;
                     // A repeated packet is acknowledged again but not counted twice
                     if (rxPid[3] == tog[ep]) begin
                        next_tog[ep] = ~tog[ep]; // [R14]
                        next_rxPktEvent = 1'b1; // [R22]
                     end
                     if (ep == uet_pkg::EP_CTL && stage == uet_pkg::CS_STATUS_OUT) begin
                        next_stage = uet_pkg::CS_IDLE;
                     end
                  end
               end
            end
         end
         uet_pkg::ST_TX_WAIT: begin
            if (txDone) begin
               next_state = uet_pkg::ST_HS_WAIT;
               next_hsTimer = '0;
            end
         end
         uet_pkg::ST_HS_WAIT: begin
            next_hsTimer = hsTimer + 1'b1;
            if (rxPktValid) begin
               next_state = uet_pkg::ST_IDLE;
               if (rxPidOk && rxPid == uet_pkg::PID_ACK) begin // [R3]
                  next_inAckEvent = 1'b1; // [R22]
                  next_inAckEp = ep;
                  if (txZeroLen) begin
                     next_stage = uet_pkg::CS_IDLE;
                     if (reqSetAddr) begin
                        next_devAddr = pendAddr; // [R20]
                        next_reqSetAddr = 1'b0;
                     end
                  end else begin
                     next_tog[ep] = ~tog[ep]; // [R14]
                  end
               end
            end else if (hsTimer >= HS_WAIT) begin
               // Host stays silent on a corrupt packet, so the data is resent later
               next_state = uet_pkg::ST_IDLE; // [R6]
            end
         end
         default: begin
            next_state = uet_pkg::ST_IDLE;
         end
      endcase
      if (busReset) begin
         next_state = uet_pkg::ST_IDLE;
         next_stage = uet_pkg::CS_IDLE;
         next_tog = '0;
         next_devAddr = uet_pkg::DEFAULT_ADDR; // [R24]
         next_reqSetAddr = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state <= uet_pkg::ST_IDLE;
         stage <= uet_pkg::CS_IDLE;
         ep <= '0;
         isSetup <= 1'b0;
         overrun <= 1'b0;
         byteCnt <= '0;
         reqDirIn <= 1'b0;
         reqSetAddr <= 1'b0;
         pendAddr <= '0;
         lenLoZero <= 1'b0;
         lenZero <= 1'b0;
         tog <= '0;
         hsTimer <= '0;
         devAddr <= uet_pkg::DEFAULT_ADDR;
         txHsValid <= 1'b0;
         txHsPid <= '0;
         txDataReq <= 1'b0;
         txDataPid <= '0;
         txDataEp <= '0;
         txZeroLen <= 1'b0;
         rxPktEvent <= 1'b0;
         rxPktEp <= '0;
         inAckEvent <= 1'b0;
         inAckEp <= '0;
         setupEvent <= 1'b0;
      end else begin
         state <= next_state;
         stage <= next_stage;
         ep <= next_ep;
         isSetup <= next_isSetup;
         overrun <= next_overrun;
         byteCnt <= next_byteCnt;
         reqDirIn <= next_reqDirIn;
         reqSetAddr <= next_reqSetAddr;
         pendAddr <= next_pendAddr;
         lenLoZero <= next_lenLoZero;
         lenZero <= next_lenZero;
         tog <= next_tog;
         hsTimer <= next_hsTimer;
         devAddr <= next_devAddr;
         txHsValid <= next_txHsValid;
         txHsPid <= next_txHsPid;
         txDataReq <= next_txDataReq;
         txDataPid <= next_txDataPid;
         txDataEp <= next_txDataEp;
         txZeroLen <= next_txZeroLen;
         rxPktEvent <= next_rxPktEvent;
         rxPktEp <= next_rxPktEp;
         inAckEvent <= next_inAckEvent;
         inAckEp <= next_inAckEp;
         setupEvent <= next_setupEvent;
      end
   end

   AST_DATA_ONLY_ON_IN: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
      txDataReq |-> $past(rxPktValid) && ($past(rxPid) == uet_pkg::PID_IN))
      else $error("Data sent without an IN token");
   AST_NAK_WITHOUT_DATA: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
      (state == uet_pkg::ST_IDLE) && !busReset && rxPktValid && tokOk && rxPid == uet_pkg::PID_IN
      && epTok == uet_pkg::EP_BULK_IN && !epStall[2] && !inReady[2]
      |=> txHsValid && txHsPid == uet_pkg::PID_NAK && !txDataReq)
      else $error("IN without data was not answered NAK");
   AST_STALL_IN: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
      (state == uet_pkg::ST_IDLE) && !busReset && rxPktValid && tokOk && rxPid == uet_pkg::PID_IN
      && epStall[epTok] |=> txHsValid && txHsPid == uet_pkg::PID_STALL && !txDataReq)
      else $error("Stalled endpoint did not answer STALL");
   AST_ERROR_SILENT: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
      (state == uet_pkg::ST_RX_DATA) && rxPktValid && !(rxCrcOk && rxPidOk) |=> !txHsValid && state == uet_pkg::ST_IDLE)
      else $error("Handshake sent after a damaged packet");
   AST_SETUP_ACK: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
      (state == uet_pkg::ST_RX_DATA) && isSetup && rxPktValid && dataOk && !busReset
      |=> txHsValid && txHsPid == uet_pkg::PID_ACK && setupEvent && tog[0])
      else $error("Good SETUP packet not acknowledged");
   AST_FOREIGN_ADDR: assert property (@(posedge mclk) disable iff (!rst_n) // [R24]
      (state == uet_pkg::ST_IDLE) && rxPktValid && rxAddr != devAddr
      |=> !txHsValid && !txDataReq && state == uet_pkg::ST_IDLE)
      else $error("Token to another address was answered");
   AST_BAD_ENDPOINT: assert property (@(posedge mclk) disable iff (!rst_n) // [R25]
      (state == uet_pkg::ST_IDLE) && rxPktValid && rxEndp > uet_pkg::EP_MAX
      |=> !txHsValid && !txDataReq && state == uet_pkg::ST_IDLE)
      else $error("Token to an invalid endpoint was answered");
   AST_SOF_IGNORED: assert property (@(posedge mclk) disable iff (!rst_n) // [R26]
      (state == uet_pkg::ST_IDLE) && rxPktValid && (rxPid == uet_pkg::PID_SOF || rxPid == uet_pkg::PID_PRE)
      |=> state == uet_pkg::ST_IDLE && !txHsValid)
      else $error("Frame marker or preamble was not ignored");
   AST_STATUS_DATA1: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
      txDataReq && txZeroLen |-> txDataPid == uet_pkg::PID_DATA1 && stage == uet_pkg::CS_STATUS_IN)
      else $error("Status stage not sent as DATA1");
   AST_HS_WAIT_BOUNDED: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
      $rose(state == uet_pkg::ST_HS_WAIT) |-> ##[1:HS_BOUND] state != uet_pkg::ST_HS_WAIT)
      else $error("Handshake wait did not end");
   AST_ADDR_AFTER_STATUS: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
      (state == uet_pkg::ST_HS_WAIT) && rxPktValid && rxPidOk && rxPid == uet_pkg::PID_ACK
      && txZeroLen && reqSetAddr && !busReset |=> devAddr == $past(pendAddr))
      else $error("Device address not taken after status stage");
endmodule

// ===== uet_host_model.sv
// Host controller model: drives received packets and data bytes
`timescale 1ns/1ps
module uet_host_model (
   input wire logic mclk,
   output logic rxPktValid = 1'b0,
   output logic [3:0] rxPid = 4'h0,
   output logic rxCrcOk = 1'b0,
   output logic rxByteValid = 1'b0,
   output logic [7:0] rxByte = 8'h00
);
   // Strobes stay up over back-to-back calls; idle drops them and scrambles fields
   task pkt(input logic [3:0] pid, input logic crc);
      rxByteValid = 1'b0;
      rxPid = pid;
      rxCrcOk = crc;
      rxPktValid = 1'b1;
      @(negedge mclk);
   endtask
   task byt(input logic [7:0] b);
      rxPktValid = 1'b0;
      rxByte = b;
      rxByteValid = 1'b1;
      @(negedge mclk);
   endtask
   task idle;
      rxPktValid = 1'b0;
      rxByteValid = 1'b0;
      rxPid = ~rxPid;
      rxCrcOk = ~rxCrcOk;
      rxByte = ~rxByte;
   endtask
endmodule

// ===== usb_endpoint_transaction_handler_test.sv
// Self-checking bench for the endpoint transaction handler
`timescale 1ns/1ps
module usb_endpoint_transaction_handler_test;
   logic mclk = 1'b0, rst_n = 1'b0, txDone = 1'b0, ep0DataEnd = 1'b0, fifoReady = 1'b0, busReset = 1'b0;
   logic rxPktValid, rxCrcOk, rxByteValid, fifoValid, txHsValid, txDataReq, txZeroLen;
   logic rxPktEvent, inAckEvent, setupEvent;
   logic [1:0] rxPktEp, inAckEp, txDataEp;
   logic [3:0] rxPid, txHsPid, txDataPid, rxEndp = 4'h0;
   logic [6:0] a = 7'h00, devAddr;
   logic [2:0] inReady = 3'h0, epStall = 3'h0, outEnable = 3'h0, ctlStage;
   logic [7:0] rxByte, fifoData;
   logic [7:0] sb [8];
   logic [7:0] q [$];
   int fails = 0, n_tests = 0, cyc = 0, seed = 32'hcd38, nRx = 0, nAck = 0, nTx = 0;
   always #10 mclk = ~mclk;
   uet_host_model u_host (.mclk(mclk), .rxPktValid(rxPktValid), .rxPid(rxPid), .rxCrcOk(rxCrcOk),
      .rxByteValid(rxByteValid), .rxByte(rxByte));
   // Short handshake wait keeps the lost-ACK case brief
   uet_transaction_handler #(.HS_WAIT(16'h000a)) u_dut (.mclk(mclk), .rst_n(rst_n), .busReset(busReset),
      .rxPktValid(rxPktValid), .rxPid(rxPid), .rxPidOk(1'b1), .rxCrcOk(rxCrcOk), .rxAddr(a), .rxEndp(rxEndp),
      .rxByteValid(rxByteValid), .rxByte(rxByte), .txDone(txDone), .inReady(inReady), .epStall(epStall),
      .outEnable(outEnable), .ep0DataEnd(ep0DataEnd), .fifoReady(fifoReady), .fifoValid(fifoValid),
      .fifoData(fifoData), .txHsValid(txHsValid), .txHsPid(txHsPid), .txDataReq(txDataReq),
      .txDataPid(txDataPid), .txDataEp(txDataEp), .txZeroLen(txZeroLen), .rxPktEvent(rxPktEvent),
      .rxPktEp(rxPktEp), .inAckEvent(inAckEvent), .inAckEp(inAckEp), .setupEvent(setupEvent), .devAddr(devAddr),
      .ctlStage(ctlStage));
   task chk(input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("Counts: %0d compares, %0d mismatches", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Token, optional data packet, then the answer seen in the next four cycles (0 means silence)
   task xfer(input logic [3:0] tok, ep, dp, input int n, input logic crc, input logic [3:0] e, input string nm);
      logic [3:0] got;
      logic [7:0] b;
      got = 4'h0;
      rxEndp = ep;
      u_host.pkt(tok, 1'b1);
      if (dp != 4'h0) begin
         for (int i = 0; i < n; i++) begin
            b = (tok == uet_pkg::PID_SETUP) ? sb[i] : 8'($random(seed));
            q.push_back(b);
            u_host.byt(b);
         end
         u_host.pkt(dp, crc);
      end
      u_host.idle;
      repeat (4) begin
         if (txHsValid === 1'b1) got = txHsPid;
         if (txDataReq === 1'b1) got = txDataPid;
         @(negedge mclk);
      end
      chk(8'(got), 8'(e));
      $display("test %s done", nm);
   endtask
   task drain;
      fifoReady = 1'b1;
      while (q.size() > 0) begin
         chk(8'(fifoValid), 8'h01);
         chk(fifoData, q.pop_front());
         @(negedge mclk);
      end
      fifoReady = 1'b0;
   endtask
   task done_ack(input logic ok);
      txDone = 1'b1;
      @(negedge mclk);
      txDone = 1'b0;
      if (ok) u_host.pkt(uet_pkg::PID_ACK, 1'b1);
      else repeat (14) @(negedge mclk);
      u_host.idle;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc > 5000) begin
         fails++;
         end_sim;
      end
   end
   // 16 per pulse plus endpoint; a setup pulse adds 64
   always @(negedge mclk) begin
      if (rxPktEvent) nRx += 16 + rxPktEp;
      if (setupEvent) nRx += 64;
      if (inAckEvent) nAck += 16 + inAckEp;
      if (txDataReq) nTx += 16 + txDataEp;
   end
   initial begin
      for (int i = 0; i < 8; i++) sb[i] = 8'h00;
      sb[1] = uet_pkg::REQ_SET_ADDRESS;
      sb[2] = {2'b01, 6'($random(seed))};
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      chk(8'(devAddr), 8'h00);
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, uet_pkg::PID_NAK, "in nak");
      epStall = 3'h6;
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, uet_pkg::PID_STALL, "in stall");
      xfer(uet_pkg::PID_OUT, 4'h1, uet_pkg::PID_DATA0, 0, 1'b1, uet_pkg::PID_STALL, "out stall");
      epStall = 3'h0;
      outEnable = 3'h2;
      xfer(uet_pkg::PID_OUT, 4'h1, uet_pkg::PID_DATA0, 4, 1'b1, uet_pkg::PID_ACK, "out ack");
      drain;
      xfer(uet_pkg::PID_OUT, 4'h1, uet_pkg::PID_DATA1, 0, 1'b0, 4'h0, "out crc");
      outEnable = 3'h0;
      xfer(uet_pkg::PID_OUT, 4'h1, uet_pkg::PID_DATA1, 0, 1'b1, uet_pkg::PID_NAK, "out nak");
      xfer(uet_pkg::PID_IN, 4'h3, 4'h0, 0, 1'b1, 4'h0, "bad ep");
      xfer(uet_pkg::PID_SOF, 4'h0, 4'h0, 0, 1'b1, 4'h0, "sof");
      inReady = 3'h4;
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, uet_pkg::PID_DATA0, "in d0");
      done_ack(1'b1);
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, uet_pkg::PID_DATA1, "in d1");
      done_ack(1'b0);
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, uet_pkg::PID_DATA1, "in retry");
      done_ack(1'b1);
      xfer(uet_pkg::PID_SETUP, 4'h0, uet_pkg::PID_DATA0, 8, 1'b1, uet_pkg::PID_ACK, "setup");
      chk(8'(ctlStage), 8'(uet_pkg::CS_STATUS_IN));
      drain;
      ep0DataEnd = 1'b1;
      xfer(uet_pkg::PID_IN, 4'h0, 4'h0, 0, 1'b1, uet_pkg::PID_DATA1, "status");
      chk(8'(txZeroLen), 8'h01);
      done_ack(1'b1);
      @(negedge mclk);
      chk(8'(devAddr), sb[2]);
      inReady = 3'h0;
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, 4'h0, "old addr");
      a = sb[2][6:0];
      xfer(uet_pkg::PID_IN, 4'h2, 4'h0, 0, 1'b1, uet_pkg::PID_NAK, "new addr");
      chk(8'(nRx), 8'h61);
      chk(8'(nAck), 8'h34);
      chk(8'(nTx), 8'h46);
      busReset = 1'b1;
      @(negedge mclk);
      busReset = 1'b0;
      chk(8'(devAddr), 8'h00);
      end_sim;
   end
endmodule
